// ---- rtl/cbf_pkg.sv ----
package cbf_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_STATE = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  // ****************************************
  // Interface modes
  // ****************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_RX_ONLY = 2'h1;
  localparam logic [1:0] MODE_TXRX = 2'h2;
  localparam logic [1:0] MODE_RST = 2'h2;

  // ****************************************
  // Flag and state fields
  // ****************************************
  localparam int unsigned FLG_SHORT = 0;
  localparam int unsigned FLG_CLAMP = 1;
  localparam int unsigned FLG_RXD = 2;
  localparam int unsigned FLG_TXD = 3;
  localparam int unsigned FLG_CLS_LSB = 4;
  localparam int unsigned FLG_W = 7;
  localparam int unsigned EVT_W = 4;
  localparam logic [6:0] FLAGS_RST = 7'h00;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam int unsigned ST_DRV_EN = 0;
  localparam int unsigned ST_DRV_OFF = 1;
  localparam int unsigned ST_RXD_OE = 2;
  localparam int unsigned ST_TXD = 3;
  localparam int unsigned ST_RX = 4;
  localparam int unsigned ST_REC_FAULT = 5;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned TXD_TIMEOUT_US = 300;
  localparam int unsigned TXD_TIMEOUT_CYC = TXD_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned CLAMP_CYC_DEF = 1000;
  localparam logic [2:0] CONFIRM_CNT = 3'h5;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic low_line_ground_cmp;
    logic high_line_ground_cmp;
    logic low_line_battery_cmp;
    logic high_line_battery_cmp;
    logic low_line_five_volt_cmp;
    logic high_line_five_volt_cmp;
  } cbf_cmp_s;

  typedef struct packed {
    logic txd;
    logic rx_diff;
    logic rxd_sense;
    cbf_cmp_s cmp;
  } cbf_pins_s;

  // Idle pins: transmit and receiver recessive, comparators in their no-fault recessive state
  localparam logic [8:0] PINS_RST = 9'h1B0;

  typedef enum logic [2:0] {
    FAULT_NONE = 3'h0,
    FAULT_L_GND = 3'h1,
    FAULT_H_GND = 3'h2,
    FAULT_L_BAT = 3'h3,
    FAULT_H_BAT = 3'h4,
    FAULT_L_5V = 3'h5,
    FAULT_H_5V = 3'h6
  } cbf_fault_e;

endpackage : cbf_pkg

// ---- rtl/cbf_sync.sv ----
`timescale 1ns/1ns

module cbf_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  generate
    if (W < 1) begin : g_bad_w
      $error("cbf_sync width must be at least one");
    end
  endgenerate

  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST;
      q <= RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : cbf_sync

// ---- rtl/cbf_short_mon.sv ----
`timescale 1ns/1ns

module cbf_short_mon (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic drv_dom,
  input wire cbf_pkg::cbf_cmp_s cmp,
  output logic rec_fault,
  output logic confirm,
  output cbf_pkg::cbf_fault_e fault_cls
);

  cbf_pkg::cbf_cmp_s rec_smp_r;
  cbf_pkg::cbf_cmp_s dom_smp_r;
  cbf_pkg::cbf_fault_e cls_now;
  logic dom_d_r;
  logic have_rec_r;
  logic cycle_done;
  logic [2:0] cnt_r;

  // ****************************************
  // Classification
  // ****************************************
  function automatic cbf_pkg::cbf_fault_e classify(input cbf_pkg::cbf_cmp_s r, input cbf_pkg::cbf_cmp_s d);
    cbf_pkg::cbf_fault_e f;
    f = cbf_pkg::FAULT_NONE;
    if (!r.low_line_ground_cmp && !r.high_line_ground_cmp) begin
      f = d.high_line_ground_cmp ? cbf_pkg::FAULT_L_GND : cbf_pkg::FAULT_H_GND; // [RULE_14]
    end else if (r.low_line_battery_cmp && r.high_line_battery_cmp) begin
      if (d.low_line_battery_cmp) f = cbf_pkg::FAULT_L_BAT; // [RULE_15]
      else if (d.high_line_battery_cmp) f = cbf_pkg::FAULT_H_BAT;
    end else if (r.low_line_five_volt_cmp && r.high_line_five_volt_cmp) begin
      if (d.low_line_five_volt_cmp) f = cbf_pkg::FAULT_L_5V; // [RULE_16]
      else if (d.high_line_five_volt_cmp) f = cbf_pkg::FAULT_H_5V;
    end
    return f;
  endfunction : classify

  // Line identity needs the dominant sample; recessive alone only says a short exists
  assign cls_now = classify(rec_smp_r, dom_smp_r); // [RULE_02]
  assign cycle_done = dom_d_r && !drv_dom && have_rec_r; // [RULE_01]

  // ****************************************
  // Sampling per driver phase
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dom_d_r <= 1'b0;
      have_rec_r <= 1'b0;
      rec_smp_r <= '0;
      dom_smp_r <= '0;
      rec_fault <= 1'b0;
    end else begin
      dom_d_r <= drv_dom;
      if (!drv_dom) begin
        rec_smp_r <= cmp;
        have_rec_r <= 1'b1;
        rec_fault <= (!cmp.low_line_ground_cmp && !cmp.high_line_ground_cmp)
          || (cmp.low_line_battery_cmp && cmp.high_line_battery_cmp)
          || (cmp.low_line_five_volt_cmp && cmp.high_line_five_volt_cmp); // [RULE_02]
      end else begin
        dom_smp_r <= cmp;
      end
    end
  end

  // ****************************************
  // Five-cycle confirmation
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      fault_cls <= cbf_pkg::FAULT_NONE;
      confirm <= 1'b0;
    end else begin
      confirm <= 1'b0;
      if (cycle_done) begin
        fault_cls <= cls_now;
        if (cls_now == cbf_pkg::FAULT_NONE) begin
          cnt_r <= 3'h0; // [RULE_17]
        end else if (cls_now == fault_cls && cnt_r != 3'h0) begin
          if (cnt_r != cbf_pkg::CONFIRM_CNT) begin
            cnt_r <= cnt_r + 3'h1;
          end
          confirm <= (cnt_r == cbf_pkg::CONFIRM_CNT - 3'h1); // [RULE_01]
        end else begin
          cnt_r <= 3'h1; // [RULE_17]
        end
      end
    end
  end

endmodule : cbf_short_mon

// ---- rtl/cbf_top.sv ----
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns

//Contract
//[RULE_01] Report a bus short only after five agreeing recessive-dominant cycles.
//[RULE_02] Recessive samples detect a short; dominant samples identify the shorted line.
//[RULE_03] Bus dominant longer than the clamp time sets a readable bus failure flag.
//[RULE_04] At each receiver low-to-high edge, sample RXD; high means stuck recessive.
//[RULE_05] Stuck RXD sets its flag, forces receive-only mode, disables the RXD driver.
//[RULE_06] The stuck-RXD flag is its own status bit, apart from other failure bits.
//[RULE_07] Stuck-RXD condition recovers internally when TXD is sampled low.
//[RULE_08] The C variant omits stuck-RXD detection and its flag.
//[RULE_09] TXD low past timeout disables driver, releases bus, sets TXD-dominant flag.
//[RULE_10] Driver returns on Normal mode command or receiver falling with TXD recessive.
//[RULE_11] TXD shorted to RXD is released by the timeout and recovers likewise.
//[RULE_12] Driver stays off until pin failures vanish and flags are cleared by reading.
//[RULE_13] Host rewrites transmit/receive mode to re-enable the driver.
//[RULE_14] Ground comparators classify low-line and high-line shorts to ground.
//[RULE_15] Battery comparators classify low-line and high-line shorts to battery.
//[RULE_16] Five-volt comparators classify low-line and high-line shorts to five volts.
//[RULE_17] Confirmation count restarts when a cycle gives another or no classification.
//[RULE_18] Transmit timeout and clamp time are synthesis-time cycle counts.
module cbf_top #(
  parameter int unsigned C_VARIANT = 0,
  parameter int unsigned TXD_TO_CYC = cbf_pkg::TXD_TIMEOUT_CYC,
  parameter int unsigned CLAMP_CYC = cbf_pkg::CLAMP_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cbf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic txd_pin,
  input wire logic rx_diff_pin,
  input wire logic rxd_sense_pin,
  input wire cbf_pkg::cbf_cmp_s cmp_pin,
  output logic drv_en,
  output logic drv_dominant,
  output logic rxd_out,
  output logic rxd_oe,
  output logic irq
);

  localparam int unsigned TW = $clog2(TXD_TO_CYC + 1);
  localparam int unsigned CW = $clog2(CLAMP_CYC + 1);
  localparam logic [TW-1:0] TXD_LAST = TW'(TXD_TO_CYC - 1); // [RULE_18]
  localparam logic [CW-1:0] CLAMP_LAST = CW'(CLAMP_CYC - 1); // [RULE_18]
  localparam logic DET_EN = (C_VARIANT == 0); // [RULE_08]

  generate
    if (C_VARIANT > 1 || TXD_TO_CYC < 2 || CLAMP_CYC < 2) begin : g_bad_param
      $error("cbf_top parameters out of range");
    end
  endgenerate

  logic rst_ff1_r;
  logic rst_n;
  cbf_pkg::cbf_pins_s pins_s;
  logic txd_s;
  logic rx_s;
  logic rsense_s;
  logic rx_d_r;
  logic rx_rise;
  logic rx_fall;
  logic [TW-1:0] txd_cnt_r;
  logic [CW-1:0] clamp_cnt_r;
  logic txd_evt;
  logic clamp_evt;
  logic stuck_evt;
  logic stuck_r;
  logic drv_off_r;
  logic drv_en_r;
  logic drv_en_nxt;
  logic drv_dom_r;
  logic recover_req;
  logic [1:0] mode_r;
  logic [cbf_pkg::FLG_W-1:0] flags_r;
  logic [cbf_pkg::FLG_W-1:0] flags_nxt;
  logic [cbf_pkg::FLG_W-1:0] rd_snap_r;
  logic [cbf_pkg::EVT_W-1:0] evt;
  logic [cbf_pkg::EVT_W-1:0] irq_stat_r;
  logic [cbf_pkg::EVT_W-1:0] irq_mask_r;
  logic rec_fault;
  logic short_cfm;
  cbf_pkg::cbf_fault_e fault_cls;
  logic setup;
  logic access;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic rd_flags;
  logic mode_wr_txrx;
  logic [31:0] rd_mux;
  logic rd_err;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic rxd_out_r;

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_ff1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff1_r <= 1'b1;
      rst_n <= rst_ff1_r;
    end
  end

  cbf_sync #(
    .W($bits(cbf_pkg::cbf_pins_s)),
    .RST(cbf_pkg::PINS_RST)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({txd_pin, rx_diff_pin, rxd_sense_pin, cmp_pin}),
    .q(pins_s)
  );

  assign txd_s = pins_s.txd;
  assign rx_s = pins_s.rx_diff;
  assign rsense_s = pins_s.rxd_sense;
  assign rx_rise = rx_s && !rx_d_r;
  assign rx_fall = !rx_s && rx_d_r;

  // ****************************************
  // Bus short supervision
  // ****************************************
  cbf_short_mon u_short (
    .mclk(mclk),
    .rst_n(rst_n),
    .drv_dom(drv_dom_r),
    .cmp(pins_s.cmp),
    .rec_fault(rec_fault),
    .confirm(short_cfm),
    .fault_cls(fault_cls)
  );

  // ****************************************
  // Timeouts
  // ****************************************
  assign txd_evt = !txd_s && drv_en_r && (txd_cnt_r == TXD_LAST); // [RULE_09]
  assign clamp_evt = !rx_s && (clamp_cnt_r == CLAMP_LAST); // [RULE_03]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txd_cnt_r <= '0;
    end else if (txd_s || !drv_en_r) begin
      txd_cnt_r <= '0;
    end else if (txd_cnt_r != TW'(TXD_TO_CYC)) begin
      txd_cnt_r <= txd_cnt_r + TW'(1); // [RULE_09]
    end
  end

  // Saturates so one long clamp gives a single event, not one per wrap
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clamp_cnt_r <= '0;
    end else if (rx_s) begin
      clamp_cnt_r <= '0;
    end else if (clamp_cnt_r != CW'(CLAMP_CYC)) begin
      clamp_cnt_r <= clamp_cnt_r + CW'(1); // [RULE_03]
    end
  end

  // ****************************************
  // Receive output supervision
  // ****************************************
  // Both pins go through the same synchroniser, so the sensed RXD lags as little as the receiver
  assign stuck_evt = DET_EN && rx_rise && rsense_s && !stuck_r; // [RULE_04]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stuck_r <= 1'b0;
      rx_d_r <= 1'b1;
      rxd_out_r <= 1'b1;
    end else begin
      rx_d_r <= rx_s;
      rxd_out_r <= rx_s;
      if (stuck_evt) begin
        stuck_r <= 1'b1; // [RULE_05]
      end else if (!txd_s) begin
        stuck_r <= 1'b0; // [RULE_07]
      end
    end
  end

  assign rxd_out = rxd_out_r;
  assign rxd_oe = !stuck_r; // [RULE_05]

  // ****************************************
  // Bus driver control
  // ****************************************
  // Either recovery path still waits for idle TXD and read-cleared pin flags
  assign recover_req = mode_wr_txrx || (rx_fall && txd_s); // [RULE_10] [RULE_11] [RULE_13]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drv_off_r <= 1'b0;
    end else if (txd_evt || stuck_evt) begin
      drv_off_r <= 1'b1; // [RULE_09] [RULE_05]
    end else if (recover_req && txd_s && !stuck_r && !flags_r[cbf_pkg::FLG_TXD] && !flags_r[cbf_pkg::FLG_RXD]) begin
      drv_off_r <= 1'b0; // [RULE_12]
    end
  end

  // Enabling waits for recessive TXD so the bus is never grabbed mid-dominant
  assign drv_en_nxt = (mode_r == cbf_pkg::MODE_TXRX) && !drv_off_r && !txd_evt && !stuck_evt && (drv_en_r || txd_s);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drv_en_r <= 1'b0;
      drv_dom_r <= 1'b0;
    end else begin
      drv_en_r <= drv_en_nxt;
      drv_dom_r <= drv_en_nxt && !txd_s; // [RULE_09]
    end
  end

  assign drv_en = drv_en_r;
  assign drv_dominant = drv_dom_r;

  // ****************************************
  // APB slave
  // ****************************************
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = access;
  assign wr_ctrl = access && pwrite && (paddr == cbf_pkg::OFF_CTRL);
  assign wr_stat = access && pwrite && (paddr == cbf_pkg::OFF_IRQ_STAT);
  assign wr_mask = access && pwrite && (paddr == cbf_pkg::OFF_IRQ_MASK);
  assign rd_flags = access && !pwrite && (paddr == cbf_pkg::OFF_FLAGS);
  assign mode_wr_txrx = wr_ctrl && (pwdata[1:0] == cbf_pkg::MODE_TXRX);

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr)
      cbf_pkg::OFF_CTRL: rd_mux[1:0] = mode_r;
      cbf_pkg::OFF_FLAGS: rd_mux[cbf_pkg::FLG_W-1:0] = flags_r;
      cbf_pkg::OFF_STATE: begin
        rd_mux[cbf_pkg::ST_DRV_EN] = drv_en_r;
        rd_mux[cbf_pkg::ST_DRV_OFF] = drv_off_r;
        rd_mux[cbf_pkg::ST_RXD_OE] = !stuck_r;
        rd_mux[cbf_pkg::ST_TXD] = txd_s;
        rd_mux[cbf_pkg::ST_RX] = rx_s;
        rd_mux[cbf_pkg::ST_REC_FAULT] = rec_fault;
      end
      cbf_pkg::OFF_IRQ_STAT: rd_mux[cbf_pkg::EVT_W-1:0] = irq_stat_r;
      cbf_pkg::OFF_IRQ_MASK: rd_mux[cbf_pkg::EVT_W-1:0] = irq_mask_r;
      default: rd_err = 1'b1;
    endcase
  end

  // Read data is captured in setup so it comes from a flop; the clear later removes only what was shown
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      rd_snap_r <= '0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= rd_err;
      rd_snap_r <= flags_r;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r && access;

  // ****************************************
  // Mode and failure flags
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= cbf_pkg::MODE_RST;
    end else if (stuck_evt) begin
      mode_r <= cbf_pkg::MODE_RX_ONLY; // [RULE_05]
    end else if (wr_ctrl) begin
      mode_r <= pwdata[1:0]; // [RULE_13]
    end
  end

  assign evt[cbf_pkg::FLG_SHORT] = short_cfm; // [RULE_01]
  assign evt[cbf_pkg::FLG_CLAMP] = clamp_evt; // [RULE_03]
  assign evt[cbf_pkg::FLG_RXD] = stuck_evt; // [RULE_06]
  assign evt[cbf_pkg::FLG_TXD] = txd_evt; // [RULE_09]

  always_comb begin
    flags_nxt = rd_flags ? (flags_r & ~rd_snap_r) : flags_r; // [RULE_12]
    flags_nxt[cbf_pkg::EVT_W-1:0] = flags_nxt[cbf_pkg::EVT_W-1:0] | evt;
    if (short_cfm) begin
      flags_nxt[cbf_pkg::FLG_CLS_LSB +: 3] = fault_cls; // [RULE_02]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= cbf_pkg::FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= cbf_pkg::IRQ_RST;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_stat ? pwdata[cbf_pkg::EVT_W-1:0] : cbf_pkg::IRQ_RST)) | evt;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_r <= cbf_pkg::IRQ_RST;
    end else if (wr_mask) begin
      irq_mask_r <= pwdata[cbf_pkg::EVT_W-1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ****************************************
  // Assertions
  // ****************************************
  a_txd_release: // [RULE_09]
    assert property (@(posedge mclk) disable iff (!rst_n) txd_evt |=> drv_off_r && !drv_en_r && !drv_dom_r
      && flags_r[cbf_pkg::FLG_TXD]) else $error("transmit timeout did not release the bus");

  a_drv_held_off: // [RULE_12]
    assert property (@(posedge mclk) disable iff (!rst_n) drv_off_r |=> !drv_en_r)
      else $error("driver enabled while blocked");

  a_reenable_cond: // [RULE_10]
    assert property (@(posedge mclk) disable iff (!rst_n) $fell(drv_off_r) |-> $past(txd_s)
      && !$past(flags_r[cbf_pkg::FLG_TXD]) && !$past(flags_r[cbf_pkg::FLG_RXD]) && $past(recover_req))
      else $error("driver unblocked without recovery condition");

  a_clamp_flag: // [RULE_03]
    assert property (@(posedge mclk) disable iff (!rst_n) clamp_evt |=> flags_r[cbf_pkg::FLG_CLAMP]
      && irq_stat_r[cbf_pkg::FLG_CLAMP]) else $error("clamp flag not set");

  a_stuck_cause: // [RULE_04]
    assert property (@(posedge mclk) disable iff (!rst_n) $rose(stuck_r) |-> $past(rx_rise) && $past(rsense_s))
      else $error("stuck receive output without cause");

  a_rx_only: // [RULE_05]
    assert property (@(posedge mclk) disable iff (!rst_n) stuck_evt |=> mode_r == cbf_pkg::MODE_RX_ONLY
      && !rxd_oe && flags_r[cbf_pkg::FLG_RXD] && !drv_en_r) else $error("stuck receive output not handled");

  a_stuck_recover: // [RULE_07]
    assert property (@(posedge mclk) disable iff (!rst_n) stuck_r && !txd_s |=> !stuck_r)
      else $error("stuck receive output did not recover");

  a_variant_off: // [RULE_08]
    assert property (@(posedge mclk) disable iff (!rst_n) (C_VARIANT != 0) |-> !stuck_r && !flags_r[cbf_pkg::FLG_RXD])
      else $error("variant detection present");

  a_short_report: // [RULE_01]
    assert property (@(posedge mclk) disable iff (!rst_n) short_cfm |=> flags_r[cbf_pkg::FLG_SHORT]
      && flags_r[cbf_pkg::FLG_CLS_LSB +: 3] == $past(fault_cls)) else $error("short not reported");

  a_flag_sticky: // [RULE_06]
    assert property (@(posedge mclk) disable iff (!rst_n) flags_r[cbf_pkg::FLG_RXD] && !rd_flags
      |=> flags_r[cbf_pkg::FLG_RXD]) else $error("receive flag lost without a read");

endmodule : cbf_top

// ---- bench/cbf_can_ctrl_model.sv ----
`timescale 1ns/1ns

// ****************************************
// Controller pins and bus comparators
// ****************************************
module cbf_can_ctrl_model (
  input wire logic mclk,
  input wire logic tx_req,
  input wire cbf_pkg::cbf_fault_e fault,
  input wire logic clamp,
  input wire logic rxd_short_hi,
  input wire logic drv_en,
  input wire logic drv_dominant,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  output logic txd_pin,
  output logic rx_diff_pin,
  output logic rxd_sense_pin,
  output cbf_pkg::cbf_cmp_s cmp_pin
);
  logic dom;
  always_ff @(posedge mclk) begin
    txd_pin <= tx_req;
  end
  assign dom = drv_en & drv_dominant;
  // A clamped bus reads dominant whatever the driver does
  assign rx_diff_pin = ~(dom | clamp);
  // Released pin floats to the controller's pull-up
  assign rxd_sense_pin = rxd_short_hi | ~rxd_oe | rxd_out;
  always_comb begin
    cmp_pin = dom ? 6'h10 : 6'h30;
    case (fault)
      cbf_pkg::FAULT_L_GND: cmp_pin = dom ? 6'h10 : 6'h00;
      cbf_pkg::FAULT_H_GND: cmp_pin = 6'h00;
      cbf_pkg::FAULT_L_BAT: cmp_pin[3:2] = 2'h3;
      cbf_pkg::FAULT_H_BAT: cmp_pin[3:2] = dom ? 2'h1 : 2'h3;
      cbf_pkg::FAULT_L_5V: cmp_pin[1:0] = 2'h3;
      cbf_pkg::FAULT_H_5V: cmp_pin[1:0] = dom ? 2'h1 : 2'h3;
      default: ;
    endcase
  end
endmodule : cbf_can_ctrl_model

// ---- bench/tb_can_bus_fault_supervisor.sv ----
`timescale 1ns/1ns

module tb_can_bus_fault_supervisor;
  localparam int unsigned TO = 8;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, tx_req, clamp, rxd_short_hi, err;
  logic txd_pin, rx_diff_pin, rxd_sense_pin, drv_en, drv_dominant, rxd_out, rxd_oe, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  cbf_pkg::cbf_cmp_s cmp_pin;
  cbf_pkg::cbf_fault_e fault;
  int failures, cmp_count, cycles;

  cbf_top #(.C_VARIANT(0), .TXD_TO_CYC(TO), .CLAMP_CYC(16)) dut (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .txd_pin(txd_pin), .rx_diff_pin(rx_diff_pin), .rxd_sense_pin(rxd_sense_pin),
    .cmp_pin(cmp_pin), .drv_en(drv_en), .drv_dominant(drv_dominant), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .irq(irq));
  cbf_can_ctrl_model mcu (.mclk(mclk), .tx_req(tx_req), .fault(fault), .clamp(clamp),
    .rxd_short_hi(rxd_short_hi), .drv_en(drv_en), .drv_dominant(drv_dominant), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_pin(txd_pin), .rx_diff_pin(rx_diff_pin), .rxd_sense_pin(rxd_sense_pin),
    .cmp_pin(cmp_pin));

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // A hang costs a mismatch rather than a stuck run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // Called just after an edge; gap of one edge keeps psel from double assignment
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic toggle(input int n);
    repeat (n) begin
      tx_req <= 1'b0;
      cyc(4);
      tx_req <= 1'b1;
      cyc(8);
    end
  endtask : toggle

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_req = 1'b1;
    clamp = 1'b0;
    rxd_short_hi = 1'b0;
    fault = cbf_pkg::FAULT_NONE;
    cyc(3);
    rstn <= 1'b1;
    cyc(10);
    apb(1'b0, cbf_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk({31'h0, drv_en}, 32'h1);
    tx_req <= 1'b0;
    cyc(5);
    chk({31'h0, drv_dominant}, 32'h1);
    cyc(TO + 1);
    chk({30'h0, drv_en, drv_dominant}, 32'h0);
    tx_req <= 1'b1;
    cyc(4);
    apb(1'b0, cbf_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h8);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, cbf_pkg::OFF_IRQ_MASK, 32'h8);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, cbf_pkg::OFF_IRQ_STAT, 32'h8);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, cbf_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h8);
    cyc(4);
    chk({31'h0, drv_en}, 32'h0);
    clamp <= 1'b1;
    cyc(3);
    clamp <= 1'b0;
    cyc(6);
    chk({31'h0, drv_en}, 32'h1);
    clamp <= 1'b1;
    cyc(24);
    chk({31'h0, rxd_out}, 32'h0);
    clamp <= 1'b0;
    cyc(4);
    apb(1'b0, cbf_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h2);
    rxd_short_hi <= 1'b1;
    clamp <= 1'b1;
    cyc(4);
    clamp <= 1'b0;
    cyc(6);
    chk({30'h0, rxd_oe, drv_en}, 32'h0);
    apb(1'b0, cbf_pkg::OFF_CTRL, 32'h0);
    chk(rd, {30'h0, cbf_pkg::MODE_RX_ONLY});
    apb(1'b0, cbf_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h4);
    apb(1'b1, cbf_pkg::OFF_CTRL, {30'h0, cbf_pkg::MODE_TXRX});
    cyc(4);
    chk({31'h0, drv_en}, 32'h0);
    rxd_short_hi <= 1'b0;
    tx_req <= 1'b0;
    cyc(2);
    tx_req <= 1'b1;
    cyc(5);
    chk({31'h0, rxd_oe}, 32'h1);
    apb(1'b1, cbf_pkg::OFF_CTRL, {30'h0, cbf_pkg::MODE_TXRX});
    cyc(5);
    chk({31'h0, drv_en}, 32'h1);
    for (int c = 1; c <= 6; c++) begin
      fault <= cbf_pkg::cbf_fault_e'(c);
      cyc(4);
      apb(1'b0, cbf_pkg::OFF_FLAGS, 32'h0);
      toggle(4);
      apb(1'b0, cbf_pkg::OFF_FLAGS, 32'h0);
      chk(rd, 32'h0);
      toggle(1);
      apb(1'b0, cbf_pkg::OFF_FLAGS, 32'h0);
      chk(rd, {25'h0, 3'(c), 4'h1});
    end
    fault <= cbf_pkg::FAULT_L_GND;
    toggle(3);
    fault <= cbf_pkg::FAULT_NONE;
    toggle(1);
    fault <= cbf_pkg::FAULT_L_GND;
    toggle(4);
    apb(1'b0, cbf_pkg::OFF_FLAGS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, cbf_pkg::OFF_CTRL, {30'h0, cbf_pkg::MODE_OFF});
    cyc(2);
    chk({31'h0, drv_en}, 32'h0);
    apb(1'b0, cbf_pkg::OFF_STATE, 32'h0);
    chk(rd, 32'h3C);
    conclude();
  end
endmodule : tb_can_bus_fault_supervisor
